// File: inc/pd_pkg.sv
`default_nettype none
package pd_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 125_000_000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint INACT_SEC = 30;
  localparam longint INVALID_NS = 30_000;
  localparam longint VALID_SET_NS = 1_000;
  localparam longint RESUME_NS = 100_000;
  // Least times round up, longest times round down
  localparam logic [31:0] INACT_CYCLES_DEF = 32'(INACT_SEC * CLK_HZ);
  localparam logic [15:0] INVALID_CYCLES_DEF =
    16'((INVALID_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [15:0] VALID_CYCLES_DEF =
    16'((VALID_SET_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [15:0] RESUME_CYCLES_DEF = 16'((RESUME_NS * CLK_HZ) / NS_PER_S);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] REG_INACT = 12'h008;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_RX_GATE_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_AUTO_BIT = 1;
  localparam int STAT_MANUAL_BIT = 2;
  localparam int STAT_EXPIRED_BIT = 3;
  localparam int STAT_VALID_BIT = 4;
  localparam int STAT_READY_BIT = 5;
  localparam int STAT_ARMED_BIT = 6;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_AUTO_PD = 3'b010,
    ST_MANUAL_PD = 3'b100
  } pd_state_e;

endpackage
`default_nettype wire

// File: inc/sync_bus_if.sv
`default_nettype none
interface sync_bus_if #(
  parameter int W = 1
);
  logic [W-1:0] level;
  logic [W-1:0] change;
  modport src(output level, output change);
  modport dst(input level, input change);
endinterface
`default_nettype wire

// File: rtl/input_settle.sv
`default_nettype none
module input_settle #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_raw,
  sync_bus_if.src bus
);
  import pd_pkg::*;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  if (W < 1) begin : g_bad_width
    $error("input_settle needs at least one input");
  end

  // ----------------------------------------------------------------
  // Three-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= i_raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ----------------------------------------------------------------
  // Settled level and one-cycle change pulse
  // ----------------------------------------------------------------
  // A change counts only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        bus.level[i] <= 1'b0;
        bus.change[i] <= 1'b0;
      end else begin
        bus.change[i] <= (stage2[i] == stage3[i]) && (stage3[i] != bus.level[i]);
        if (stage2[i] == stage3[i]) begin
          bus.level[i] <= stage3[i];
        end
      end
    end
  end

endmodule // input_settle
`default_nettype wire

// File: rtl/serial_transceiver_powerdown_ctrl.sv
`default_nettype none
// How it works
// - Powerdown stops pump, floats every transmitter
// - Force-sleep low always wins
// - Both controls high: always active
// - Auto powerdown armed only awake low, sleep_n high
// - Thirty quiet seconds while armed: power down
// - Any line transition wakes from auto powerdown
// - Timer stays expired until an awake edge (rise or fall) or a line transition
// - Leave manual powerdown: both high or transition
// - Awake falling edge restarts thirty second count
// - Ready to transmit within 100 us
// - Valid flag low after 30 us invalid
// - Valid flag high 1 us after valid
// - Validity works in all modes, no power effect
// - Monitor variant floats receivers in manual powerdown
// - Cable detach: down until valid and transition
// - Tied controls act as one shutdown input
// - Ready low in powerdown, high after recovery
module serial_transceiver_powerdown_ctrl #(
  parameter int NTX = 3,
  parameter int NRX = 5,
  parameter logic [31:0] INACT_CYCLES = pd_pkg::INACT_CYCLES_DEF,
  parameter logic [15:0] INVALID_CYCLES = pd_pkg::INVALID_CYCLES_DEF,
  parameter logic [15:0] VALID_CYCLES = pd_pkg::VALID_CYCLES_DEF,
  parameter logic [15:0] RESUME_CYCLES = pd_pkg::RESUME_CYCLES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [pd_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NTX-1:0] i_tx_in,
  input wire logic [NRX-1:0] i_rx_in,
  input wire logic [NRX-1:0] i_rx_level_ok,
  input wire logic i_force_awake_in,
  input wire logic i_force_sleep_n_in,
  input wire logic i_supply_ok,
  output logic o_pump_en,
  output logic [NTX-1:0] o_tx_oe,
  output logic o_rx_oe,
  output logic o_monitor_rx_out,
  output logic o_levels_valid,
  output logic o_ready
);
  import pd_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (NTX < 1 || NRX < 1) begin : g_bad_count
    $error("Need at least one transmitter and one receiver");
  end
  if (INACT_CYCLES < 32'h0000_0002 || INVALID_CYCLES < 16'h0002) begin : g_bad_timer
    $error("Timer limits too small");
  end
  if (VALID_CYCLES < 16'h0002 || RESUME_CYCLES < 16'h0002) begin : g_bad_wake
    $error("Wake limits too small");
  end

  // ----------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------
  localparam int RX_LO = NTX;
  localparam int OK_LO = NTX + NRX;
  localparam int AWAKE_IX = NTX + 2 * NRX;
  localparam int SLEEP_IX = AWAKE_IX + 1;
  localparam int SUPPLY_IX = AWAKE_IX + 2;
  localparam int SW = AWAKE_IX + 3;

  logic [SW-1:0] raw;
  assign raw = {i_supply_ok, i_force_sleep_n_in, i_force_awake_in, i_rx_level_ok, i_rx_in,
    i_tx_in};

  sync_bus_if #(.W(SW)) sbus();

  input_settle #(.W(SW)) u_settle (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_raw(raw),
    .bus(sbus.src)
  );

  logic activity;
  logic awake_lvl;
  logic sleep_n_lvl;
  logic awake_rise;
  logic awake_fall;
  logic supply_lvl;
  logic any_valid;
  logic armed;

  assign activity = |sbus.change[OK_LO-1:0];
  assign awake_lvl = sbus.level[AWAKE_IX];
  assign sleep_n_lvl = sbus.level[SLEEP_IX];
  assign awake_rise = sbus.change[AWAKE_IX] && sbus.level[AWAKE_IX];
  assign awake_fall = sbus.change[AWAKE_IX] && !sbus.level[AWAKE_IX];
  assign supply_lvl = sbus.level[SUPPLY_IX];
  assign any_valid = |sbus.level[SW-4:OK_LO];
  // Tied controls can never arm, so they act as one shutdown pin
  assign armed = !awake_lvl && sleep_n_lvl;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  pd_state_e state;
  pd_state_e next_state;
  logic [31:0] inact_cnt;
  logic expired;
  logic inact_done;

  assign inact_done = armed && !activity && (inact_cnt == INACT_CYCLES - 32'h0000_0001);

  always_comb begin
    next_state = state;
    if (!sleep_n_lvl) begin
      next_state = ST_MANUAL_PD;
    end else begin
      case (state)
        ST_ACTIVE: begin
          if (inact_done) begin
            next_state = ST_AUTO_PD;
          end
        end
        ST_AUTO_PD: begin
          if (activity || awake_lvl) begin
            next_state = ST_ACTIVE;
          end
        end
        ST_MANUAL_PD: begin
          // Released with no wake cause: expired timer keeps it down
          if (activity || awake_lvl) begin
            next_state = ST_ACTIVE;
          end else begin
            next_state = ST_AUTO_PD;
          end
        end
        default: begin
          next_state = ST_MANUAL_PD;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Inactivity timer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      inact_cnt <= '0;
    end else if (activity || !armed || awake_fall) begin
      inact_cnt <= '0;
    end else if (!expired && inact_cnt != INACT_CYCLES - 32'h0000_0001) begin
      inact_cnt <= inact_cnt + 32'h0000_0001;
    end
  end

  // Entry wins over a same-cycle clear so a forced sleep is never lost
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      expired <= 1'b0;
    end else if (next_state != ST_ACTIVE) begin
      expired <= 1'b1;
    end else if (activity || awake_rise || awake_fall) begin
      expired <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] resume_cnt;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pump_en <= 1'b1;
      o_tx_oe <= '1;
      o_rx_oe <= 1'b1;
    end else begin
      o_pump_en <= next_state == ST_ACTIVE;
      o_tx_oe <= {NTX{next_state == ST_ACTIVE}};
      o_rx_oe <= !(next_state == ST_MANUAL_PD && ctrl[CTRL_RX_GATE_BIT]);
    end
  end

  // Monitor receiver stays live whatever the power state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_monitor_rx_out <= 1'b0;
    end else begin
      o_monitor_rx_out <= sbus.level[RX_LO];
    end
  end

  // Supply flag may never come; the counter caps the wait
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      resume_cnt <= '0;
    end else if (state != ST_ACTIVE || o_ready) begin
      resume_cnt <= '0;
    end else begin
      resume_cnt <= resume_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
    end else if (next_state != ST_ACTIVE) begin
      o_ready <= 1'b0;
    end else if (state == ST_ACTIVE && (supply_lvl ||
        resume_cnt == RESUME_CYCLES - 16'h0001)) begin
      o_ready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Line level validity
  // ----------------------------------------------------------------
  // Independent of power state; a system may feed it back to the controls
  logic [15:0] invalid_cnt;
  logic [15:0] valid_cnt;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      invalid_cnt <= '0;
    end else if (any_valid) begin
      invalid_cnt <= '0;
    end else if (invalid_cnt != INVALID_CYCLES) begin
      invalid_cnt <= invalid_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      valid_cnt <= '0;
    end else if (!any_valid) begin
      valid_cnt <= '0;
    end else if (valid_cnt != VALID_CYCLES - 16'h0001) begin
      valid_cnt <= valid_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_levels_valid <= 1'b0;
    end else if (!any_valid && invalid_cnt == INVALID_CYCLES) begin
      o_levels_valid <= 1'b0;
    end else if (any_valid && valid_cnt == VALID_CYCLES - 16'h0001) begin
      o_levels_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic acc_start;
  logic acc_done;
  logic hit;
  logic [31:0] rd_mux;
  logic [31:0] status;

  assign acc_start = i_psel && i_penable && !o_pready;
  assign acc_done = i_psel && i_penable && o_pready;

  always_comb begin
    status = '0;
    status[STAT_ACTIVE_BIT] = state == ST_ACTIVE;
    status[STAT_AUTO_BIT] = state == ST_AUTO_PD;
    status[STAT_MANUAL_BIT] = state == ST_MANUAL_PD;
    status[STAT_EXPIRED_BIT] = expired;
    status[STAT_VALID_BIT] = o_levels_valid;
    status[STAT_READY_BIT] = o_ready;
    status[STAT_ARMED_BIT] = armed;
  end

  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    case (i_paddr)
      REG_CTRL: begin
        rd_mux = ctrl;
      end
      REG_STATUS: begin
        rd_mux = status;
      end
      REG_INACT: begin
        rd_mux = inact_cnt;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc_start;
      if (acc_start) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
        o_pslverr <= !hit;
      end
    end
  end

  // Write lands on the edge that completes the transfer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (acc_done && i_pwrite && i_paddr == REG_CTRL) begin
      ctrl <= i_pwdata & CTRL_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_sleep_forces_down: assert property (!sleep_n_lvl |=> state == ST_MANUAL_PD)
    else $error("Force-sleep did not power down");
  a_pd_outputs_off: assert property ((state != ST_ACTIVE) |-> (!o_pump_en && o_tx_oe == '0))
    else $error("Pump or transmitter live in powerdown");
  a_forced_awake_on: assert property ((awake_lvl && sleep_n_lvl) |=> state == ST_ACTIVE)
    else $error("Both controls high but not active");
  a_auto_needs_arm: assert property ((state == ST_ACTIVE && !armed) |=> state != ST_AUTO_PD)
    else $error("Automatic powerdown while not armed");
  a_quiet_enters_pd: assert property ((state == ST_ACTIVE && sleep_n_lvl && inact_done)
      |=> state == ST_AUTO_PD && expired)
    else $error("Inactivity expiry did not power down");
  a_edge_wakes: assert property ((state == ST_AUTO_PD && activity && sleep_n_lvl)
      |=> state == ST_ACTIVE && o_pump_en)
    else $error("Transition did not wake");
  a_expired_holds: assert property ((expired && !activity && !awake_rise && !awake_fall)
      |=> expired)
    else $error("Timer left expired without cause");
  a_manual_release: assert property ((state == ST_MANUAL_PD && sleep_n_lvl && !awake_lvl
      && !activity) |=> state == ST_AUTO_PD)
    else $error("Left manual powerdown without cause");
  a_fall_restarts: assert property ((awake_fall && sleep_n_lvl && state == ST_ACTIVE)
      |=> (inact_cnt == 32'h0000_0000 && state == ST_ACTIVE))
    else $error("Awake fall did not restart count");
  a_resume_bound: assert property ((state == ST_ACTIVE && !o_ready && sleep_n_lvl
      && resume_cnt == RESUME_CYCLES - 16'h0001 && next_state == ST_ACTIVE) |=> o_ready)
    else $error("Ready not reached in time");
  a_invalid_drop: assert property ((!any_valid && invalid_cnt == INVALID_CYCLES)
      |=> !o_levels_valid)
    else $error("Valid flag stayed high");
  a_valid_rise: assert property ((any_valid && valid_cnt == VALID_CYCLES - 16'h0001)
      |=> o_levels_valid)
    else $error("Valid flag did not rise");
  a_rx_gated: assert property ((next_state == ST_MANUAL_PD && ctrl[CTRL_RX_GATE_BIT])
      |=> !o_rx_oe)
    else $error("Receivers live in manual powerdown");
  a_ready_low_pd: assert property ((state != ST_ACTIVE) |-> !o_ready)
    else $error("Ready high in powerdown");

endmodule // serial_transceiver_powerdown_ctrl
`default_nettype wire

// File: sim/host_pm_model.sv
`default_nettype none
module host_pm_model (
  input wire logic i_clk,
  input wire logic [1:0] i_mode,
  input wire logic i_awake_cmd,
  input wire logic i_sleep_n_cmd,
  input wire logic i_levels_valid,
  output logic o_force_awake_in,
  output logic o_force_sleep_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Control pins
  // ----------------------------------------------------------------
  // Board logic: pins settle just after the edge, never mid-cycle
  always @(posedge i_clk) begin
    case (i_mode)
      2'd1: begin
        o_force_awake_in <= i_levels_valid;
        o_force_sleep_n_in <= i_levels_valid;
      end
      2'd2: begin
        o_force_awake_in <= i_sleep_n_cmd;  // Tied pins
        o_force_sleep_n_in <= i_sleep_n_cmd;
      end
      2'd3: begin
        o_force_awake_in <= 1'b0;  // Hybrid wiring
        o_force_sleep_n_in <= i_levels_valid;
      end
      default: begin
        o_force_awake_in <= i_awake_cmd;  // High for manual only
        o_force_sleep_n_in <= i_sleep_n_cmd;
      end
    endcase
  end
endmodule // host_pm_model
`default_nettype wire

// File: sim/tb_serial_transceiver_powerdown_ctrl.sv
`default_nettype none
module tb_serial_transceiver_powerdown_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import pd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct {logic awake; logic sleep_n; int wait_n; logic pump;} row_s;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, supply_ok;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] tx_in, tx_oe;
  logic [4:0] rx_in, rx_ok;
  logic [1:0] mode;
  logic awake_cmd, sleep_n_cmd, f_awake, f_sleep_n, err;
  logic pump, rx_oe, mon, valid, ready;
  int fail_count, n_checks, cycles;
  // Awake falls at row 3; row 4 crosses the 200-cycle limit
  row_s rows[8] = '{'{1, 1, 300, 1}, '{1, 0, 10, 0}, '{1, 1, 10, 1}, '{0, 1, 100, 1},
    '{0, 1, 120, 0}, '{0, 0, 10, 0}, '{0, 1, 20, 0}, '{1, 1, 10, 1}};
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  serial_transceiver_powerdown_ctrl #(.INACT_CYCLES(32'd200), .INVALID_CYCLES(16'd20),
    .VALID_CYCLES(16'd5), .RESUME_CYCLES(16'd40)) i_dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_tx_in(tx_in), .i_rx_in(rx_in), .i_rx_level_ok(rx_ok), .i_force_awake_in(f_awake),
    .i_force_sleep_n_in(f_sleep_n), .i_supply_ok(supply_ok), .o_pump_en(pump),
    .o_tx_oe(tx_oe), .o_rx_oe(rx_oe), .o_monitor_rx_out(mon), .o_levels_valid(valid),
    .o_ready(ready));
  host_pm_model i_host (.i_clk(clk), .i_mode(mode), .i_awake_cmd(awake_cmd),
    .i_sleep_n_cmd(sleep_n_cmd), .i_levels_valid(valid), .o_force_awake_in(f_awake),
    .o_force_sleep_n_in(f_sleep_n));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole sequence needs about 1400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, tx_in, rx_in} = '0;
    {fail_count, n_checks, mode} = '0;
    rx_ok = 5'h1f;
    supply_ok = 1'b1;
    awake_cmd = 1'b1;
    sleep_n_cmd = 1'b1;
    cyc(3);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      awake_cmd <= rows[i].awake;
      sleep_n_cmd <= rows[i].sleep_n;
      cyc(rows[i].wait_n);
      check(pump, rows[i].pump);
      check(tx_oe, {3{rows[i].pump}});
      check(ready, rows[i].pump);
    end
    // Auto powerdown, then wake on a transmitter edge
    awake_cmd <= 1'b0;
    cyc(220);
    check(pump, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h0000_005a);
    apb(1'b0, 12'h00c, 32'h0);
    check({31'h0, err}, 32'h0000_0001);  // Unmapped place
    check(rd, 32'h0000_0000);  // Unmapped place
    tx_in <= 3'b010;
    cyc(10);
    check(pump, 1'b1);
    // Manual powerdown with receiver gating, slow supply
    supply_ok <= 1'b0;
    sleep_n_cmd <= 1'b0;
    cyc(10);
    check(ready, 1'b0);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, CTRL_RESET);
    check(rx_oe, 1'b0);
    rx_in <= 5'h01;
    cyc(8);
    check(mon, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0);
    cyc(3);
    check(rx_oe, 1'b1);
    apb(1'b1, REG_CTRL, CTRL_RESET);
    awake_cmd <= 1'b1;
    sleep_n_cmd <= 1'b1;
    cyc(10);
    check({pump, ready}, 2'b10);
    cyc(40);
    check(ready, 1'b1);
    supply_ok <= 1'b1;
    // Validity flag timing, no effect on power
    rx_ok <= 5'h00;
    cyc(30);
    check({valid, pump}, 2'b01);
    rx_ok <= 5'h04;
    cyc(3);
    check(valid, 1'b0);
    cyc(9);
    check(valid, 1'b1);
    // Host wiring variants
    mode <= 2'd1;
    rx_ok <= 5'h00;
    cyc(40);
    check(pump, 1'b0);
    rx_ok <= 5'h1f;
    cyc(30);
    check(pump, 1'b1);
    mode <= 2'd3;
    rx_ok <= 5'h00;
    cyc(40);
    check(pump, 1'b0);
    rx_ok <= 5'h1f;
    cyc(30);
    check(pump, 1'b0);
    rx_in <= 5'h05;
    cyc(10);
    check(pump, 1'b1);
    mode <= 2'd2;
    sleep_n_cmd <= 1'b0;
    cyc(10);
    check(pump, 1'b0);
    sleep_n_cmd <= 1'b1;
    cyc(250);
    check(pump, 1'b1);
    // Second reset in mid-run
    rst_n <= 1'b0;
    cyc(3);
    check({pump, tx_oe, rx_oe, ready}, 6'b111110);
    // Settled sleep pin reads low until the synchroniser refills
    rst_n <= 1'b1;
    cyc(2);
    check(pump, 1'b0);
    cyc(10);
    check(pump, 1'b1);
    complete_run;
  end
endmodule // tb_serial_transceiver_powerdown_ctrl
`default_nettype wire
